// ===== src/alarm_channel.sv
`timescale 1ns/1ns
`default_nettype none
module alarm_channel (
    // Clock, reset and time base.
    input wire logic mclk,
    input wire logic rst,
    input wire logic tick,
    input wire logic flash,
    // Displayed value.
    input wire logic valueStrobe,
    input wire logic signed [31:0] value,
    // Settings.
    input wire alarm_monitor_pkg::alarm_cfg_s cfg,
    input wire logic enable,
    input wire logic ackPulse,
    // Results.
    output logic condition,
    output logic active,
    output logic lamp,
    output logic activateEvt
);
    logic signed [32:0] vx, hx, lx, hy;
    logic newCond;
    logic [15:0] tripCnt_reg;
    logic acked_reg;

    // Compare at 33 bits so setpoint plus or minus hysteresis never wraps.
    always_comb
    begin
        vx = {value[31], value};
        hx = {cfg.hiSp[31], cfg.hiSp};
        lx = {cfg.loSp[31], cfg.loSp};
        hy = {17'h0, cfg.hyst};
        // R6: overlap inside band
        if (cfg.hiEn && cfg.loEn && hx < lx)
            newCond = condition ? (vx >= hx - hy && vx <= lx + hy) : (vx >= hx && vx <= lx);
        // R5: alarm outside normal band
        // R2: high trip, R3: low trip, R13: release with hysteresis
        else
            newCond = condition ?
                ((cfg.hiEn && vx >= hx - hy) || (cfg.loEn && vx <= lx + hy)) :
                ((cfg.hiEn && vx >= hx) || (cfg.loEn && vx <= lx));
    end

    // R15: evaluate per update
    always_ff @(posedge mclk)
    begin
        if (rst || !enable)
            condition <= 1'b0;
        else if (valueStrobe)
            condition <= newCond;
    end

    // R14: trip delay timer
    always_ff @(posedge mclk)
    begin
        if (rst || !condition)
        begin
            tripCnt_reg <= 16'h0;
            active <= 1'b0;
            activateEvt <= 1'b0;
        end
        else
        begin
            activateEvt <= !active && tripCnt_reg >= cfg.trip;
            if (tripCnt_reg >= cfg.trip)
                active <= 1'b1;
            else if (tick)
                tripCnt_reg <= tripCnt_reg + 16'h1;
        end
    end

    // R7: flash until acknowledged
    always_ff @(posedge mclk)
    begin
        if (rst || !active)
            acked_reg <= 1'b0;
        else if (ackPulse)
            acked_reg <= 1'b1;
        lamp <= !rst && active && (acked_reg || flash);
    end

    high_trip_a: assert property (@(posedge mclk) disable iff (rst) // R2
        valueStrobe && enable && !condition && cfg.hiEn && !cfg.loEn && vx >= hx |=> condition)
        else $error("High setpoint reached without alarm condition.");
    low_trip_a: assert property (@(posedge mclk) disable iff (rst) // R3
        valueStrobe && enable && !condition && cfg.loEn && !cfg.hiEn && vx <= lx |=> condition)
        else $error("Low setpoint reached without alarm condition.");
    trip_delay_a: assert property (@(posedge mclk) disable iff (rst) // R14
        $rose(active) |-> $past(condition) && $past(tripCnt_reg) >= cfg.trip)
        else $error("Alarm became active before its trip delay.");
    lamp_steady_a: assert property (@(posedge mclk) disable iff (rst) // R7
        active && acked_reg ##1 active |-> ##1 lamp)
        else $error("Acknowledged alarm lamp is not steady.");
    reeval_only_a: assert property (@(posedge mclk) disable iff (rst) // R15
        !$past(valueStrobe) && $past(enable) |-> $stable(condition))
        else $error("Condition changed without a value update.");
endmodule : alarm_channel
`default_nettype wire

// ===== src/alarm_monitor_cfg.svh
`ifndef ALARM_MONITOR_CFG_SVH
`define ALARM_MONITOR_CFG_SVH
// Register byte offsets; OFS_ values are word offsets inside an alarm block.
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_MASK 12'h008
`define ADDR_LIVE 12'h00C
`define ADDR_ACCESS 12'h010
`define ADDR_PIN1 12'h014
`define ADDR_PIN2 12'h018
`define ADDR_FUNC 12'h020
`define ADDR_ALARM 12'h100
`define OFS_HIGH 3'h0
`define OFS_LOW 3'h1
`define OFS_HYST 3'h2
`define OFS_TRIP 3'h3
`define OFS_ALCFG 3'h4
// Field positions.
`define ACC_REMOTE_LSB 4
`define LEVEL_LSB 16
`define ALCFG_RELAY_LSB 8
// Reset values and limits.
`define ALARM_COUNT_RST 4'h2
`define ALARM_COUNT_MAX 4'h8
`define CODE_MAX 16'hC350
`define HYST_RST 16'h000A
`define FLEVEL_MAX 4'h8
// Timing: a 100 ms tick, lamp flash toggles every five ticks.
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 100000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define FLASH_TICKS 3'h5
`endif

// ===== src/alarm_monitor_pkg.sv
package alarm_monitor_pkg;
    // Granted access level of a code or entry path.
    typedef enum logic [2:0] {
        LVL_NONE = 3'h0, LVL_1 = 3'h1, LVL_2 = 3'h2, LVL_3 = 3'h3,
        LVL_4 = 3'h4, LVL_5 = 3'h5, LVL_6 = 3'h6, LVL_CAL = 3'h7
    } access_level_e;
    // Level value of a user-assignable function.
    typedef enum logic [3:0] {
        FLV_DEFAULT = 4'h0, FLV_1 = 4'h1, FLV_2 = 4'h2, FLV_3 = 4'h3,
        FLV_4 = 4'h4, FLV_5 = 4'h5, FLV_6 = 4'h6, FLV_CAL = 4'h7,
        FLV_SPECIAL_CAL = 4'h8
    } func_level_e;
    // Settings of one alarm.
    typedef struct packed {
        logic signed [31:0] hiSp;
        logic signed [31:0] loSp;
        logic [15:0] hyst;
        logic [15:0] trip;
        logic hiEn;
        logic loEn;
        logic [6:0] relays;
    } alarm_cfg_s;
endpackage : alarm_monitor_pkg

// ===== src/setpoint_alarm_monitor.sv
// Contract
// R1: Zero to eight alarms, two by default.
// R2: At or above high setpoint trips alarm.
// R3: At or below low setpoint trips alarm.
// R4: Each setpoint disableable, default off.
// R5: Both set: alarm outside the band.
// R6: High below low: alarm inside band.
// R7: Lamp flashes, steady after acknowledge.
// R8: Allocated relays follow active alarm.
// R9: Eight by seven relay allocation matrix.
// R10: Two PIN codes up to 50000, levels.
// R11: Four 16-bit function codes with levels.
// R12: Easy and remote access levels, default none.
// R13: Release only past hysteresis band.
// R14: Trip after unbroken delay, break restarts.
// R15: Re-evaluate each value update, signed.
`include "alarm_monitor_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module setpoint_alarm_monitor #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // AXI4-Lite write channels.
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels.
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Displayed value and front button.
    input wire logic signed [31:0] dispValue,
    input wire logic dispStrobe,
    input wire logic ackButton,
    // Relays, lamps and interrupt.
    output logic [6:0] relayOut,
    output logic [7:0] lampOut,
    output logic irq
);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    alarm_monitor_pkg::alarm_cfg_s alarmCfg_reg [8];
    logic [3:0] alarmCount_reg;
    logic [7:0] status_reg, mask_reg;
    alarm_monitor_pkg::access_level_e easyLevel_reg, remoteLevel_reg;
    logic [15:0] pinCode_reg [2];
    alarm_monitor_pkg::access_level_e pinLevel_reg [2];
    logic [15:0] funcCode_reg [4];
    alarm_monitor_pkg::func_level_e funcLevel_reg [4];
    logic [11:0] wrAddr_reg;
    logic [31:0] wrData_reg;
    logic [3:0] wrStrb_reg;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [6:0] relay_reg;
    logic irq_reg, ackPrev_reg, flash_reg;
    logic [2:0] flashCnt_reg;
    logic tick, doWrite, ackPulse;
    logic [32:0] wrLook, rdLook;
    logic [31:0] wrData, byteMask;
    logic [7:0] cond, active, lamp, evt;
    logic [6:0] relayNext;

    // Read decode shared by reads and by read-modify-write of byte lanes.
    function automatic logic [32:0] regRead(input logic [11:0] a);
        logic [32:0] r;
        logic [2:0] idx;
        r = 33'h0;
        idx = a[7:5];
        if (a[11:2] == `ADDR_CTRL >> 2)
            r = {1'b1, 28'h0, alarmCount_reg};
        else if (a[11:2] == `ADDR_STATUS >> 2)
            r = {1'b1, 24'h0, status_reg};
        else if (a[11:2] == `ADDR_MASK >> 2)
            r = {1'b1, 24'h0, mask_reg};
        else if (a[11:2] == `ADDR_LIVE >> 2)
            r = {1'b1, 16'h0, cond, active};
        else if (a[11:2] == `ADDR_ACCESS >> 2)
            r = {1'b1, 25'h0, remoteLevel_reg, 1'b0, easyLevel_reg};
        else if (a[11:2] == `ADDR_PIN1 >> 2 || a[11:2] == `ADDR_PIN2 >> 2)
            r = {1'b1, 13'h0, pinLevel_reg[a[3]], pinCode_reg[a[3]]};
        else if (a[11:4] == `ADDR_FUNC >> 4)
            r = {1'b1, 12'h0, funcLevel_reg[a[3:2]], funcCode_reg[a[3:2]]};
        else if (a[11:8] == `ADDR_ALARM >> 8 && a[4:2] == `OFS_HIGH)
            r = {1'b1, alarmCfg_reg[idx].hiSp};
        else if (a[11:8] == `ADDR_ALARM >> 8 && a[4:2] == `OFS_LOW)
            r = {1'b1, alarmCfg_reg[idx].loSp};
        else if (a[11:8] == `ADDR_ALARM >> 8 && a[4:2] == `OFS_HYST)
            r = {1'b1, 16'h0, alarmCfg_reg[idx].hyst};
        else if (a[11:8] == `ADDR_ALARM >> 8 && a[4:2] == `OFS_TRIP)
            r = {1'b1, 16'h0, alarmCfg_reg[idx].trip};
        else if (a[11:8] == `ADDR_ALARM >> 8 && a[4:2] == `OFS_ALCFG)
            r = {1'b1, 17'h0, alarmCfg_reg[idx].relays, 6'h0,
                 alarmCfg_reg[idx].loEn, alarmCfg_reg[idx].hiEn};
        return r;
    endfunction : regRead

    // Merge the written byte lanes over the current contents.
    always_comb
    begin
        for (int b = 0; b < 4; b++)
            byteMask[8 * b +: 8] = {8{wrStrb_reg[b]}};
        wrLook = regRead(wrAddr_reg);
        rdLook = regRead(araddr);
        wrData = (wrLook[31:0] & ~byteMask) | (wrData_reg & byteMask);
        doWrite = !awready_reg && !wready_reg && !bvalid_reg;
    end

    // Address and data are taken in either order; both wait for the response.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            wrAddr_reg <= 12'h000;
            wrData_reg <= 32'h0;
            wrStrb_reg <= 4'h0;
        end
        else
        begin
            if (awvalid && awready_reg)
            begin
                wrAddr_reg <= awaddr;
                awready_reg <= 1'b0;
            end
            if (wvalid && wready_reg)
            begin
                wrData_reg <= wdata;
                wrStrb_reg <= wstrb;
                wready_reg <= 1'b0;
            end
            if (doWrite)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wrLook[32] ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_reg && bready)
            begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // One read at a time; unmapped addresses answer zero with an error.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end
        else if (arvalid && arready_reg)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rdLook[31:0];
            rresp_reg <= rdLook[32] ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_reg && rready)
        begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // Global settings; out-of-range values are refused and the old value kept.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            // R1: factory default count
            alarmCount_reg <= `ALARM_COUNT_RST;
            mask_reg <= 8'h00;
            // R12: access levels none
            easyLevel_reg <= alarm_monitor_pkg::LVL_NONE;
            remoteLevel_reg <= alarm_monitor_pkg::LVL_NONE;
        end
        else if (doWrite)
        begin
            // R1: refuse above eight
            if (wrAddr_reg[11:2] == `ADDR_CTRL >> 2 && wrData[3:0] <= `ALARM_COUNT_MAX)
                alarmCount_reg <= wrData[3:0];
            else if (wrAddr_reg[11:2] == `ADDR_MASK >> 2)
                mask_reg <= wrData[7:0];
            // R12: easy and remote levels
            else if (wrAddr_reg[11:2] == `ADDR_ACCESS >> 2)
            begin
                easyLevel_reg <= alarm_monitor_pkg::access_level_e'(wrData[2:0]);
                remoteLevel_reg <= alarm_monitor_pkg::access_level_e'(
                    wrData[`ACC_REMOTE_LSB +: 3]);
            end
        end
    end

    // R10: PIN codes and levels
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pinCode_reg <= '{16'h0000, 16'h0000};
            pinLevel_reg <= '{alarm_monitor_pkg::LVL_NONE, alarm_monitor_pkg::LVL_NONE};
        end
        else if (doWrite && (wrAddr_reg[11:2] == `ADDR_PIN1 >> 2 ||
                             wrAddr_reg[11:2] == `ADDR_PIN2 >> 2))
        begin
            if (wrData[15:0] <= `CODE_MAX)
                pinCode_reg[wrAddr_reg[3]] <= wrData[15:0];
            pinLevel_reg[wrAddr_reg[3]] <= alarm_monitor_pkg::access_level_e'(
                wrData[`LEVEL_LSB +: 3]);
        end
    end

    // R11: function codes and levels
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            funcCode_reg <= '{4{16'h0000}};
            funcLevel_reg <= '{4{alarm_monitor_pkg::FLV_DEFAULT}};
        end
        else if (doWrite && wrAddr_reg[11:4] == `ADDR_FUNC >> 4)
        begin
            funcCode_reg[wrAddr_reg[3:2]] <= wrData[15:0];
            if (wrData[`LEVEL_LSB +: 4] <= `FLEVEL_MAX)
                funcLevel_reg[wrAddr_reg[3:2]] <= alarm_monitor_pkg::func_level_e'(
                    wrData[`LEVEL_LSB +: 4]);
        end
    end

    // Per-alarm settings.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 8; i++)
            begin
                alarmCfg_reg[i].hiSp <= 32'sh0;
                alarmCfg_reg[i].loSp <= 32'sh0;
                alarmCfg_reg[i].hyst <= `HYST_RST;
                alarmCfg_reg[i].trip <= 16'h0000;
                // R4: setpoints start disabled
                alarmCfg_reg[i].hiEn <= 1'b0;
                alarmCfg_reg[i].loEn <= 1'b0;
                alarmCfg_reg[i].relays <= 7'h00;
            end
        end
        else if (doWrite && wrAddr_reg[11:8] == `ADDR_ALARM >> 8)
        begin
            if (wrAddr_reg[4:2] == `OFS_HIGH)
                alarmCfg_reg[wrAddr_reg[7:5]].hiSp <= wrData;
            else if (wrAddr_reg[4:2] == `OFS_LOW)
                alarmCfg_reg[wrAddr_reg[7:5]].loSp <= wrData;
            else if (wrAddr_reg[4:2] == `OFS_HYST && wrData[15:0] <= `CODE_MAX)
                alarmCfg_reg[wrAddr_reg[7:5]].hyst <= wrData[15:0];
            else if (wrAddr_reg[4:2] == `OFS_TRIP)
                alarmCfg_reg[wrAddr_reg[7:5]].trip <= wrData[15:0];
            else if (wrAddr_reg[4:2] == `OFS_ALCFG)
            begin
                // R4: per-setpoint enable
                alarmCfg_reg[wrAddr_reg[7:5]].hiEn <= wrData[0];
                alarmCfg_reg[wrAddr_reg[7:5]].loEn <= wrData[1];
                // R9: relay subset per alarm
                alarmCfg_reg[wrAddr_reg[7:5]].relays <= wrData[`ALCFG_RELAY_LSB +: 7];
            end
        end
    end

    // Time base for trip delays and the lamp flash.
    tick_divider #(
        .CYCLES(TICK_CYCLES)
    ) tickGen (
        .mclk(mclk),
        .rst(rst),
        .tick(tick)
    );

    // Flash phase and button edge; the button is already synchronous.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            flashCnt_reg <= 3'h0;
            flash_reg <= 1'b0;
            ackPrev_reg <= 1'b0;
        end
        else
        begin
            ackPrev_reg <= ackButton;
            if (tick && flashCnt_reg == `FLASH_TICKS - 3'h1)
            begin
                flashCnt_reg <= 3'h0;
                flash_reg <= !flash_reg;
            end
            else if (tick)
                flashCnt_reg <= flashCnt_reg + 3'h1;
        end
    end
    assign ackPulse = ackButton && !ackPrev_reg;

    // One evaluator per alarm; alarms beyond the count are held off.
    for (genvar i = 0; i < 8; i++)
    begin : chan
        alarm_channel unit (
            .mclk(mclk),
            .rst(rst),
            .tick(tick),
            .flash(flash_reg),
            .valueStrobe(dispStrobe),
            .value(dispValue),
            .cfg(alarmCfg_reg[i]),
            .enable(4'(i) < alarmCount_reg),
            .ackPulse(ackPulse),
            .condition(cond[i]),
            .active(active[i]),
            .lamp(lamp[i]),
            .activateEvt(evt[i])
        );
    end

    // R8: relay OR of alarms
    always_comb
    begin
        relayNext = 7'h00;
        for (int i = 0; i < 8; i++)
            relayNext = relayNext | ({7{active[i]}} & alarmCfg_reg[i].relays);
    end

    // Sticky status: a new activation wins over a clear in the same cycle.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            status_reg <= 8'h00;
            relay_reg <= 7'h00;
            irq_reg <= 1'b0;
        end
        else
        begin
            if (doWrite && wrAddr_reg[11:2] == `ADDR_STATUS >> 2)
                status_reg <= (status_reg & ~(wrData_reg[7:0] & byteMask[7:0])) | evt;
            else
                status_reg <= status_reg | evt;
            relay_reg <= relayNext;
            irq_reg <= |(status_reg & mask_reg);
        end
    end

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign relayOut = relay_reg;
    assign lampOut = lamp;
    assign irq = irq_reg;

    count_limit_a: assert property (@(posedge mclk) disable iff (rst) // R1
        doWrite && wrAddr_reg[11:2] == 10'h000 && wrData[3:0] > 4'h8 |=> $stable(alarmCount_reg))
        else $error("Alarm count took a value above eight.");
    disabled_sp_a: assert property (@(posedge mclk) disable iff (rst) // R4
        dispStrobe && !alarmCfg_reg[0].hiEn && !alarmCfg_reg[0].loEn |=> !cond[0])
        else $error("Alarm with both setpoints off entered condition.");
    band_inside_a: assert property (@(posedge mclk) disable iff (rst) // R5
        dispStrobe && !cond[0] && alarmCfg_reg[0].hiEn && alarmCfg_reg[0].loEn &&
        alarmCfg_reg[0].hiSp > alarmCfg_reg[0].loSp && dispValue < alarmCfg_reg[0].hiSp &&
        dispValue > alarmCfg_reg[0].loSp |=> !cond[0])
        else $error("Value inside normal band raised alarm condition.");
    overlap_band_a: assert property (@(posedge mclk) disable iff (rst) // R6
        dispStrobe && alarmCount_reg != 4'h0 && !doWrite && alarmCfg_reg[0].hiEn &&
        alarmCfg_reg[0].loEn && alarmCfg_reg[0].hiSp < alarmCfg_reg[0].loSp &&
        dispValue >= alarmCfg_reg[0].hiSp && dispValue <= alarmCfg_reg[0].loSp |=> cond[0])
        else $error("Value inside overlap band did not raise condition.");
    hyst_hold_a: assert property (@(posedge mclk) disable iff (rst) // R13
        dispStrobe && cond[0] && !doWrite && alarmCount_reg != 4'h0 &&
        alarmCfg_reg[0].hiEn && !alarmCfg_reg[0].loEn &&
        33'(signed'(dispValue)) >= 33'(signed'(alarmCfg_reg[0].hiSp)) -
        33'(signed'({1'b0, alarmCfg_reg[0].hyst})) |=> cond[0])
        else $error("High alarm released inside hysteresis band.");
    relay_map_a: assert property (@(posedge mclk) disable iff (rst) // R8
        active[0] && alarmCfg_reg[0].relays[2] |=> relayOut[2])
        else $error("Allocated relay not driven for active alarm.");
    pin_range_a: assert property (@(posedge mclk) disable iff (rst) // R10
        doWrite && wrAddr_reg[11:2] == 10'h005 && wrData[15:0] > 16'hC350
        |=> $stable(pinCode_reg[0]))
        else $error("PIN code accepted above its range.");
    func_level_a: assert property (@(posedge mclk) disable iff (rst) // R11
        doWrite && wrAddr_reg[11:2] == 10'h008 && wrData[19:16] > 4'h8
        |=> $stable(funcLevel_reg[0]))
        else $error("Function level accepted above special calibration.");
    access_rst_a: assert property (@(posedge mclk) disable iff (rst) // R12
        $past(rst) |-> easyLevel_reg == alarm_monitor_pkg::LVL_NONE &&
        remoteLevel_reg == alarm_monitor_pkg::LVL_NONE)
        else $error("Access levels not none after reset.");
endmodule : setpoint_alarm_monitor
`default_nettype wire

// ===== src/tick_divider.sv
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
    parameter int CYCLES = 10000000
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // One-cycle enable every CYCLES clocks.
    output logic tick
);
    if (CYCLES < 2)
    begin : badCycles
        $error("tick_divider needs CYCLES of at least 2.");
    end

    logic [31:0] count_reg;

    // Free-running count; the pulse marks its wrap.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            count_reg <= 32'h0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (count_reg == 32'(CYCLES - 1));
            count_reg <= (count_reg == 32'(CYCLES - 1)) ? 32'h0 : count_reg + 32'h1;
        end
    end
endmodule : tick_divider
`default_nettype wire

// ===== test/panel_model.sv
`timescale 1ns/1ns
`default_nettype none
// Front panel stand-in: shows display values and presses the acknowledge button.
module panel_model (
    // Clock.
    input wire logic mclk,
    // Display value and button.
    output logic signed [31:0] dispValue = 32'h0,
    output logic dispStrobe = 1'b0,
    output logic ackButton = 1'b0
);
    // One strobe, then enough settle time for relays and irq to follow.
    task show(input logic signed [31:0] v);
        @(posedge mclk);
        dispValue <= v;
        dispStrobe <= 1'b1;
        @(posedge mclk);
        dispStrobe <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask : show
    // Held two cycles so that the rising edge is surely seen.
    task press();
        @(posedge mclk);
        ackButton <= 1'b1;
        repeat (2) @(posedge mclk);
        ackButton <= 1'b0;
    endtask : press
endmodule : panel_model
`default_nettype wire

// ===== test/setpoint_alarm_monitor_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module setpoint_alarm_monitor_tb_top;
    logic mclk = 1'b0, rst, awvalid, wvalid, bready;
    logic arvalid, rready, awready, wready, bvalid, arready, rvalid, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv, dispValue;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs, bs;
    logic [6:0] relayOut;
    logic [7:0] lampOut;
    logic dispStrobe, ackButton;
    int mismatches = 0, total_checks = 0, seen;
    always #5 mclk = ~mclk;
    setpoint_alarm_monitor #(.TICK_CYCLES(4)) i_dut (.*);
    panel_model i_panel (.*);
    task check(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    task finish_test();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    // Address and data go out together; each is dropped once its own ready is seen.
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                do @(posedge mclk); while (awready !== 1'b1);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge mclk); while (wready !== 1'b1);
                wvalid <= 1'b0;
            end
        join
        while (bvalid !== 1'b1) @(posedge mclk);
        bs = bresp;
        bready <= 1'b0;
    endtask : wr
    task rd(input logic [11:0] a);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge mclk);
        rv = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rd
    // A hang ends the run through the same closing task.
    initial
    begin
        #200000;
        mismatches++;
        finish_test();
    end
    initial
    begin
        rst <= 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        {awaddr, araddr} <= 24'h000000;
        wdata <= 32'h0;
        wstrb <= 4'hF;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rd(12'h000); check(rv, 32'h2);
        rd(12'hFFC); check({30'h0, rs}, 32'h2);
        wr(12'hFFC, 32'h0); check({30'h0, bs}, 32'h2);
        rd(12'h010); check(rv, 32'h0);
        wr(12'h010, 32'h57); rd(12'h010); check(rv, 32'h57);
        wr(12'h014, 32'h3C351); rd(12'h014); check(rv, 32'h30000);
        // Only the low byte lane is written; the level must survive the merge.
        wstrb <= 4'h1;
        wr(12'h014, 32'hFF12); rd(12'h014); check(rv, 32'h30012);
        wstrb <= 4'hF;
        wr(12'h020, 32'h9ABCD); rd(12'h020); check(rv, 32'hABCD);
        wr(12'h000, 32'h9); rd(12'h000); check(rv, 32'h2);
        wr(12'h100, 32'h64);
        wr(12'h110, 32'h501);
        wr(12'h008, 32'h1);
        i_panel.show(100); check(relayOut, 32'h5);
        check(irq, 32'h1);
        i_panel.show(95); check(relayOut, 32'h5);
        i_panel.show(89); check(relayOut, 32'h0);
        i_panel.show(100);
        seen = 0;
        repeat (60) @(posedge mclk) seen = seen | (lampOut[0] === 1'b1 ? 2 : 1);
        check(seen, 32'h3);
        i_panel.press();
        repeat (3) @(posedge mclk);
        seen = 0;
        repeat (60) @(posedge mclk) seen += (lampOut[0] !== 1'b1);
        check(seen, 32'h0);
        wr(12'h004, 32'h1);
        // The interrupt lags the status clear by one edge.
        repeat (2) @(posedge mclk);
        check(irq, 32'h0);
        wr(12'h124, 32'h14);
        wr(12'h130, 32'h2);
        i_panel.show(20); rd(12'h00C); check(rv, 32'h202);
        wr(12'h108, 32'h0);
        wr(12'h100, 32'hA);
        wr(12'h104, 32'h32);
        wr(12'h110, 32'h3);
        i_panel.show(35); rd(12'h00C); check(rv, 32'h101);
        i_panel.show(60); rd(12'h00C); check(rv, 32'h0);
        wr(12'h100, 32'h32);
        wr(12'h104, 32'hA);
        i_panel.show(-5); rd(12'h00C); check(rv, 32'h303);
        wr(12'h110, 32'h0);
        i_panel.show(1000); rd(12'h00C); check(rv, 32'h0);
        wr(12'h10C, 32'h3);
        wr(12'h110, 32'h1);
        i_panel.show(1000); rd(12'h00C); check(rv, 32'h100);
        repeat (20) @(posedge mclk);
        rd(12'h00C); check(rv, 32'h101);
        wr(12'h000, 32'h0);
        wr(12'h110, 32'h1);
        i_panel.show(1000); rd(12'h00C); check(rv, 32'h0);
        finish_test();
    end
endmodule : setpoint_alarm_monitor_tb_top
`default_nettype wire
